// ==== src/sacs_top.sv ====
// control and timing sequencer of a 14-bit sampling converter with serial read-out
`timescale 1ns/10ps
module sacs_top
    import sacs_pkg::*;
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // serial link pins
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic             frame_sync_in,
    output logic                  sdo_out,
    output logic                  sdo_oe,
    // strap: frame sync pin takes part in framing
    input  wire logic             fs_control,
    // sampled front-end code
    input  wire logic [RES_W-1:0] analog_input,
    // status
    output logic                  power_down,
    output logic                  sampling,
    output logic                  converting,
    output logic                  init_done
);
    // -------------------------------------------------------------------
    // link side, on the serial clock
    // -------------------------------------------------------------------
    logic       link_clr;
    logic [4:0] fall_cnt;
    logic [4:0] next_fall;
    logic [4:0] rise_cnt;
    logic [4:0] frame_edges;
    logic       conv_tgl;
    logic       lsrst_1;
    logic       lsrst;
    sacs_word_t out_word;

    // frame is idle while select is high or, with frame sync in use, while sync is high
    assign link_clr  = cs_n | (fs_control & frame_sync_in);
    assign next_fall = (fall_cnt == EDGE_SAT) ? fall_cnt : fall_cnt + 5'h01;

    // reset brought into the link domain
    always_ff @(posedge sclk) begin
        lsrst_1 <= srst;
        lsrst   <= lsrst_1;
    end

    // falling edge count; pin-driven clear so edges need no clock level
    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            fall_cnt <= 5'h00;
        end else if (lsrst) begin
            fall_cnt <= 5'h00;
        end else begin
            fall_cnt <= next_fall;
        end
    end

    // sample window spans the 5th to 24th clock of the frame
    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            sampling <= 1'b0;
        end else if (lsrst) begin
            sampling <= 1'b0;
        end else begin
            sampling <= (next_fall >= WIN_OPEN) && (next_fall < EDGE_CONV);
        end
    end

    // edge total of the frame, held after it ends for the init check
    always_ff @(negedge sclk) begin
        if (lsrst) begin
            frame_edges <= 5'h00;
        end else if (!link_clr) begin
            frame_edges <= next_fall;
        end
    end

    // 24th falling edge raises a toggle for the oscillator side
    always_ff @(negedge sclk) begin
        if (lsrst) begin
            conv_tgl <= 1'b0;
        end else if (!link_clr && next_fall == EDGE_CONV && fall_cnt != EDGE_CONV) begin
            conv_tgl <= ~conv_tgl;
        end
    end

    // rising edges counted only after the first fall, so the MSB survives a leading rise
    always_ff @(posedge sclk or posedge link_clr) begin
        if (link_clr) begin
            rise_cnt <= 5'h00;
        end else if (lsrst) begin
            rise_cnt <= 5'h00;
        end else if (fall_cnt != 5'h00 && rise_cnt != BITS_OUT) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // serial data: out_word changes between frames, or on abort just after a frame opens, so it is read quasi-static here
    assign sdo_out = out_word[4'hf - rise_cnt[3:0]];
    assign sdo_oe  = !cs_n && (rise_cnt != BITS_OUT);

    // -------------------------------------------------------------------
    // crossings into the oscillator domain
    // -------------------------------------------------------------------
    logic       act_1;
    logic       act_2;
    logic       act_3;
    logic       tgl_1;
    logic       tgl_2;
    logic       tgl_3;
    logic [4:0] edges_1;
    logic [4:0] edges_2;
    logic [RES_W-1:0] ain_1;
    logic [RES_W-1:0] ain_2;

    // two stages for each level, a third only for edge detection
    always_ff @(posedge clock) begin
        if (srst) begin
            act_1   <= 1'b0;
            act_2   <= 1'b0;
            act_3   <= 1'b0;
            tgl_1   <= 1'b0;
            tgl_2   <= 1'b0;
            tgl_3   <= 1'b0;
            edges_1 <= 5'h00;
            edges_2 <= 5'h00;
            ain_1   <= '0;
            ain_2   <= '0;
        end else begin
            act_1   <= !link_clr;
            act_2   <= act_1;
            act_3   <= act_2;
            tgl_1   <= conv_tgl;
            tgl_2   <= tgl_1;
            tgl_3   <= tgl_2;
            edges_1 <= frame_edges;
            edges_2 <= edges_1;
            ain_1   <= analog_input;
            ain_2   <= ain_1;
        end
    end

    logic frame_start;
    logic frame_end;
    logic conv_go;
    logic init_frame;

    assign frame_start = act_2 && !act_3;
    assign frame_end   = !act_2 && act_3;
    assign conv_go     = tgl_2 ^ tgl_3;
    assign init_frame  = (edges_2 >= EDGE_INIT_MIN) && (edges_2 <= EDGE_INIT_MAX);

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    sacs_state_t state;
    logic        conv_start;
    logic        conv_abort;
    logic        conv_busy;
    logic        conv_done;
    logic [RES_W-1:0] conv_result;

    // a normal frame converts only once the device has been initialised
    assign conv_start = (state == st_frame) && conv_go && init_done;
    assign conv_abort = (state == st_conv) && frame_start;

    sacs_conv #(
        .CONV_N (CONV_OSC_PERIODS)
    ) u_conv (
        .clock  (clock),
        .srst   (srst),
        .start  (conv_start),
        .abort  (conv_abort),
        .sample (ain_2),
        .busy   (conv_busy),
        .done   (conv_done),
        .result (conv_result)
    );

    // frame, conversion and power-down sequence
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= st_down;
        end else begin
            case (state)
                st_down: begin
                    if (frame_start) begin
                        state <= st_frame;
                    end
                end
                st_frame: begin
                    if (conv_start) begin
                        state <= st_conv;
                    end else if (frame_end && !act_2 && edges_2 < EDGE_CONV) begin
                        state <= st_down;                // short frame, nothing to convert
                    end
                end
                st_conv: begin
                    if (conv_abort) begin
                        state <= st_frame;
                    end else if (conv_done) begin
                        state <= st_down;
                    end
                end
                default: state <= st_down;
            endcase
        end
    end

    // init flag set once by a frame of 1 to 8 falling edges and kept
    always_ff @(posedge clock) begin
        if (srst) begin
            init_done <= 1'b0;
        end else if (state == st_frame && frame_end && init_frame) begin
            init_done <= 1'b1;
        end
    end

    // output word: result of the previous frame, or the fixed code after init or abort
    always_ff @(posedge clock) begin
        if (srst) begin
            out_word <= WORD_RST;
        end else if (conv_abort) begin
            out_word <= RESET_CODE;
        end else if (state == st_frame && frame_end && init_frame) begin
            out_word <= RESET_CODE;
        end else if (conv_done) begin
            out_word <= {conv_result, PAD_FILL};
        end
    end

    // status flags
    always_ff @(posedge clock) begin
        if (srst) begin
            converting <= 1'b0;
            power_down <= 1'b1;
        end else begin
            converting <= conv_busy;                     // one flop behind busy, 20 cycles high
            if (conv_done) begin
                power_down <= 1'b1;
            end else if (frame_start) begin
                power_down <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    sequence init_end_s;
        state == st_frame && frame_end && init_frame;
    endsequence

    init_code_a: assert property (@(posedge clock) disable iff (srst)
        init_end_s |=> out_word == RESET_CODE && init_done) else $error("no fixed code after init");
    init_gate_a: assert property (@(posedge clock) disable iff (srst)
        !init_done && conv_go && !conv_busy |=> !conv_busy) else $error("conversion before init");
    abort_code_a: assert property (@(posedge clock) disable iff (srst)
        conv_abort |=> out_word == RESET_CODE && state == st_frame && !conv_busy) else $error("abort not coded");
    conv_begin_a: assert property (@(posedge clock) disable iff (srst)
        conv_start |=> conv_busy ##1 converting) else $error("conversion did not start");
    result_pipe_a: assert property (@(posedge clock) disable iff (srst)
        conv_done && !conv_abort |=> out_word == {$past(conv_result), PAD_FILL}) else $error("result not passed on");
    sleep_wake_a: assert property (@(posedge clock) disable iff (srst)
        conv_done |=> power_down && state == st_down) else $error("no power down after conversion");
    wake_a: assert property (@(posedge clock) disable iff (srst)
        state == st_down && frame_start && !conv_done |=> !power_down) else $error("no wake on frame");
    window_open_a: assert property (@(negedge sclk) disable iff (link_clr || lsrst)
        $rose(sampling) |-> fall_cnt == WIN_OPEN ##1 sampling [*8]) else $error("sample window misplaced");
    float_last_a: assert property (@(posedge sclk) disable iff (link_clr || lsrst)
        rise_cnt == BITS_OUT - 5'h01 && fall_cnt != 5'h00 |=> !sdo_oe) else $error("output not floated");
    msb_first_a: assert property (@(posedge sclk) disable iff (link_clr || lsrst)
        rise_cnt == 5'h00 && !cs_n |-> sdo_out == out_word[WORD_W-1]) else $error("msb not first");
endmodule // sacs_top

// ==== src/sacs_pkg.sv ====
// shared constants and types for the serial converter control sequencer
package sacs_pkg;
    // -------------------------------------------------------------------
    // word layout
    // -------------------------------------------------------------------
    localparam int RES_W  = 14;
    localparam int PAD_W  = 2;
    localparam int WORD_W = RES_W + PAD_W;
    localparam logic [WORD_W-1:0] RESET_CODE = 16'h3fc0;
    localparam logic [PAD_W-1:0]  PAD_FILL   = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RST   = 16'h0000;

    typedef struct packed {
        logic [RES_W-1:0] result_bits;
        logic [PAD_W-1:0] filler;
    } sacs_word_t;

    // -------------------------------------------------------------------
    // serial clock edge counts
    // -------------------------------------------------------------------
    localparam logic [4:0] EDGE_INIT_MIN = 5'h01;
    localparam logic [4:0] EDGE_INIT_MAX = 5'h08;
    localparam logic [4:0] WIN_FIRST     = 5'h05;
    localparam logic [4:0] WIN_OPEN      = WIN_FIRST - 5'h01;
    localparam logic [4:0] EDGE_CONV     = 5'h18;
    localparam logic [4:0] EDGE_SAT      = 5'h1f;
    localparam logic [4:0] BITS_OUT      = 5'h10;

    // -------------------------------------------------------------------
    // conversion timing on the internal oscillator
    // -------------------------------------------------------------------
    localparam int CLK_KHZ          = 20000;
    localparam int CONV_OSC_PERIODS = 20;
    localparam int CONV_MAX_NS      = 2670;
    localparam int CONV_MAX_CYCLES  = (CONV_MAX_NS * CLK_KHZ) / 1000000;

    typedef enum {st_down, st_frame, st_conv} sacs_state_t;
endpackage

// ==== src/sacs_conv.sv ====
// conversion timer clocked by the internal oscillator
`timescale 1ns/10ps
module sacs_conv
    import sacs_pkg::*;
#(
    parameter int CONV_N = CONV_OSC_PERIODS
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [RES_W-1:0] sample,
    // status and result
    output logic                  busy,
    output logic                  done,
    output logic [RES_W-1:0]      result
);
    localparam logic [7:0] LAST = 8'(CONV_N - 1);
    // done is registered, so it lands one cycle after the last busy cycle
    localparam int CONV_D = CONV_N + 1;

    logic [7:0] cnt;

    // run counter; abort wins over a pending finish
    always_ff @(posedge clock) begin
        if (srst || abort) begin
            busy <= 1'b0;
            cnt  <= 8'h00;
        end else if (start) begin
            busy <= 1'b1;
            cnt  <= 8'h00;
        end else if (busy) begin
            busy <= (cnt != LAST);
            cnt  <= cnt + 8'h01;
        end
    end

    // done pulse and held result, straight binary code
    always_ff @(posedge clock) begin
        if (srst) begin
            done   <= 1'b0;
            result <= '0;
        end else begin
            done <= busy && !abort && (cnt == LAST);
            if (start && !abort) begin
                result <= sample;
            end
        end
    end

    conv_busy_a: assert property (@(posedge clock) disable iff (srst)
        start && !abort |=> (busy && !done) [*8]) else $error("conversion stopped early");
    conv_len_a: assert property (@(posedge clock) disable iff (srst)
        start && !abort |-> ##CONV_D (done || !busy)) else $error("conversion not 20 periods");
endmodule // sacs_conv

// ==== tb/sacs_host.sv ====
// host serial port model: spi or dsp style framing of the converter link
`timescale 1ns/10ps
module sacs_host (
    // system clock, only to align frame starts
    input  wire logic clock,
    // link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      frame_sync_in,
    input  wire logic sdo_out,
    input  wire logic sdo_oe,
    // framing strap of the device
    input  wire logic fs_control
);
    localparam int HALF = 16;
    logic sdo_last;
    logic sdo_wire;

    // -------------------------------------------------------------------
    // data line as the host sees it
    // -------------------------------------------------------------------
    // a released line shows the inverse, so a stale bit never passes
    always @(sdo_out or sdo_oe) if (sdo_oe) sdo_last = sdo_out;
    assign sdo_wire = sdo_oe ? sdo_out : ~sdo_last;

    // idle: clock low, select high, frame sync high when unused
    initial begin
        sclk          = 1'b0;
        cs_n          = 1'b1;
        frame_sync_in = 1'b1;
        sdo_last      = 1'b0;
    end

    // -------------------------------------------------------------------
    // bus cycles
    // -------------------------------------------------------------------
    // free clock pulses, used while reset is held and again just after it is released
    task automatic pulse(input int n);
        repeat (n) begin
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
    endtask

    // one frame of nfall falling edges; lead delays the first clock
    task automatic frame(input int nfall, input int lead, output logic [15:0] word,
                         output logic oe0, output logic oe17);
        int i;
        word = 16'h0000;
        @(negedge clock);
        cs_n = 1'b0;
        if (fs_control) begin
            #HALF;
            frame_sync_in = 1'b0;
        end
        #(HALF + lead);
        oe0  = sdo_oe;
        oe17 = sdo_oe;
        for (i = 1; i <= nfall; i++) begin
            #HALF sclk = 1'b1;
            #4;
            if (i == 17) oe17 = sdo_oe;
            #(HALF - 4);
            if (i <= 16) word = {word[14:0], sdo_wire}; // capture on falling edge
            sclk = 1'b0;
        end
        #HALF;
        if (fs_control) frame_sync_in = 1'b1;
        else cs_n = 1'b1;
    endtask
endmodule // sacs_host

// ==== tb/sacs_top_tb.sv ====
// self-checking bench of the converter control sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sacs_top_tb;
    import sacs_pkg::*;
    logic             clock = 1'b0;
    logic             srst = 1'b1;
    logic             fs_control = 1'b0;
    logic [RES_W-1:0] analog_input = '0;
    logic             sclk, cs_n, frame_sync_in, sdo_out, sdo_oe;
    logic             power_down, sampling, converting, init_done;
    int               n_fail = 0;
    int               checks = 0;

    always #25 clock = ~clock;

    sacs_top dut_u (.clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n),
        .frame_sync_in(frame_sync_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .fs_control(fs_control), .analog_input(analog_input), .power_down(power_down),
        .sampling(sampling), .converting(converting), .init_done(init_done));

    sacs_host host_u (.clock(clock), .sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .fs_control(fs_control));

    // -------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // bounded wait for a conversion, then its length and power state
    task automatic wait_conv();
        int n;
        n = 0;
        while (converting !== 1'b1) begin
            @(negedge clock);
            if (++n > 100) begin n_fail++; report_and_stop(); end
        end
        `CHK(power_down, 1'b0)
        n = 0;
        while (converting === 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        `CHK(n, CONV_OSC_PERIODS)
        @(negedge clock);
        `CHK(power_down, 1'b1)
    endtask

    // full frame; sample set first, word of the previous sample expected
    task automatic normal(input logic [RES_W-1:0] val, input logic [15:0] exp, input int lead);
        logic [15:0] w;
        logic        oe0, oe17;
        @(negedge clock);
        analog_input = val;
        host_u.frame(24, lead, w, oe0, oe17);
        `CHK(w, exp)
        `CHK(oe0, 1'b1)
        `CHK(oe17, 1'b0)
    endtask

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset();
        `CHK(power_down, 1'b1)
        `CHK(converting, 1'b0)
        `CHK(init_done, 1'b0)
    endtask

    // longest legal init frame, then the fixed code
    task automatic t_init();
        logic [15:0] w;
        logic        a, b;
        int          n;
        host_u.frame(8, 0, w, a, b);
        n = 0;
        while (init_done !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        `CHK(init_done, 1'b1)
        repeat (4) @(negedge clock);
        normal(14'h2a5c, RESET_CODE, 0);
        wait_conv();
    endtask

    // pipelined results at both ends of the code range
    task automatic t_pipe();
        normal(14'h3fff, {14'h2a5c, PAD_FILL}, 0);
        wait_conv();
        normal(14'h0000, {14'h3fff, PAD_FILL}, 0);
        wait_conv();
        normal(14'h1234, {14'h0000, PAD_FILL}, 0);
    endtask

    // next frame cuts the conversion short
    task automatic t_abort();
        repeat (4) @(negedge clock);
        normal(14'h1234, RESET_CODE, 400);
        wait_conv();
        normal(14'h0abc, {14'h1234, PAD_FILL}, 0);
        wait_conv();
    endtask

    // frame sync framing with select held low
    task automatic t_fs();
        @(negedge clock);
        fs_control = 1'b1;
        repeat (4) @(negedge clock);
        normal(14'h0155, {14'h0abc, PAD_FILL}, 0);
        wait_conv();
        normal(14'h0000, {14'h0155, PAD_FILL}, 0);
        wait_conv();
    endtask

    // -------------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        host_u.pulse(4);
        repeat (10) @(negedge clock);
        t_reset();
        srst = 1'b0;
        // link-side reset only leaves on serial clock edges
        host_u.pulse(4);
        repeat (6) @(negedge clock);
        t_init();
        t_pipe();
        t_abort();
        t_fs();
        report_and_stop();
    end

    initial begin
        #2000000;
        n_fail++;
        report_and_stop();
    end
endmodule // sacs_top_tb
